// >>> rtl/base_clock_selector.sv
// base_clock_selector: glitch-free source change and divide by two of the base clock
// assumes source edges arrive as one-cycle ticks synchronous to clk_sys
`timescale 1ns/1ps
module base_clock_selector
	import clkgen_pkg::*;
(
	input  wire logic   clk_sys,
	input  wire logic   rst,
	clk_switch_if.sel   sw
);
	logic       on_mult_r;
	logic       busy_r;
	logic       half_r;
	logic [1:0] xcnt_r;
	logic [1:0] mcnt_r;
	wire        change   = sw.want_mult != on_mult_r;
	wire        src_tick = on_mult_r ? sw.mult_tick : sw.xtal_tick;
	wire        done     = (xcnt_r == SWITCH_CYCLES) && (mcnt_r == SWITCH_CYCLES);
	assign sw.on_mult  = on_mult_r;
	assign sw.busy     = busy_r;
	assign sw.base_clk = half_r;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			on_mult_r <= 1'b0;
			busy_r    <= 1'b0;
			xcnt_r    <= 2'h0;
			mcnt_r    <= 2'h0;
		end else if (!busy_r) begin
			busy_r <= change;
			xcnt_r <= 2'h0;
			mcnt_r <= 2'h0;
		end else if (done) begin
			on_mult_r <= sw.want_mult;
			busy_r    <= 1'b0;
		end else begin
			if (sw.xtal_tick && xcnt_r != SWITCH_CYCLES) xcnt_r <= xcnt_r + 2'h1;
			if (sw.mult_tick && mcnt_r != SWITCH_CYCLES) mcnt_r <= mcnt_r + 2'h1;
		end
	end
	// output held static while busy so no runt pulse appears
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) half_r <= 1'b0;
		else if (!busy_r && src_tick) half_r <= ~half_r;
	end
endmodule

// >>> rtl/clk_switch_if.sv
// clk_switch_if: request and status between control logic and the base clock selector
// assumes one clock domain, clk_sys
`timescale 1ns/1ps
interface clk_switch_if;
	logic       want_mult;
	logic       xtal_tick;
	logic       mult_tick;
	logic       on_mult;
	logic       busy;
	logic       base_clk;
	modport ctrl (output want_mult, output xtal_tick, output mult_tick,
		input on_mult, input busy, input base_clk);
	modport sel  (input want_mult, input xtal_tick, input mult_tick,
		output on_mult, output busy, output base_clk);
endinterface

// >>> rtl/clkgen_pkg.sv
// clkgen_pkg: register map, field positions and reset values of the clock generator control
// assumes a plain register port with 8-bit registers at small word offsets
package clkgen_pkg;
	localparam logic [3:0] ADDR_LOOP_CONTROL   = 4'h0;
	localparam logic [3:0] ADDR_BANDWIDTH      = 4'h1;
	localparam logic [3:0] ADDR_MULT_RANGE     = 4'h2;
	// loop control register fields
	localparam int BIT_IRQ_EN  = 7;
	localparam int BIT_FLAG    = 6;
	localparam int BIT_LOOP_ON = 5;
	localparam int BIT_BASE_SEL = 4;
	// bandwidth register fields
	localparam int BIT_AUTO  = 7;
	localparam int BIT_LOCK  = 6;
	localparam int BIT_TRACK = 5;
	// multiplier and range fields
	localparam int MUL_LSB   = 4;
	localparam int RANGE_LSB = 0;
	localparam logic [3:0] MUL_RESET      = 4'h6;
	localparam logic [3:0] RANGE_RESET    = 4'h7;
	localparam logic       LOOP_ON_RESET  = 1'b1;
	localparam logic [3:0] CTRL_UNUSED_RD = 4'hF;
	// selector waits this many cycles of each source
	localparam logic [1:0] SWITCH_CYCLES  = 2'h3;
	function automatic logic [3:0] eff_mul(input logic [3:0] m);
		return (m == 4'h0) ? 4'h1 : m;
	endfunction
endpackage

// >>> rtl/clock_generator_ctrl.sv
// clock_generator_ctrl: bandwidth control, lock tracking, programming register and base select
// assumes source clocks and frequency comparator levels come from pins outside clk_sys domain
//
// Summary of operation
// - automatic mode: track bit is read-only, follows tracking/untracking tolerance input
// - automatic mode: lock bit is read-only, follows lock/unlock tolerance input
// - automatic mode: lock toggle raises interrupt when interrupt enable is set
// - manual mode: track bit is writable, directly selects acquisition or tracking
// - manual mode disables lock bit and suppresses every interrupt
// - programming register: multiplier in upper nibble, range in lower nibble
// - multiplier zero gives the same feedback divide as multiplier one, reads back as zero
// - range zero disables loop, forbids and overrides multiplied clock selection
// - base select bit chooses crystal (0) or multiplied (1) clock
// - on source change wait three cycles of each clock, output held static
// - selector output halved and registered, base clock out is half of source
// - refuse multiplied select while loop off, refuse loop off while selected
// - loop on/off and select change cannot happen in one write
// - lock toggle sets flag, a read of loop control clears it unless a toggle falls in the same cycle
// - manual mode: interrupt enable ignores writes, reads as zero
// - reset clears track bit, filter in acquisition mode
`timescale 1ns/1ps
module clock_generator_ctrl
	import clkgen_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       crystal_clock,
	input  wire logic       multiplied_clock,
	input  wire logic       in_track_tol,
	input  wire logic       out_untrack_tol,
	input  wire logic       in_lock_tol,
	input  wire logic       out_unlock_tol,
	output logic            base_clock_out,
	output logic            clockgen_irq,
	output logic            loop_enable,
	output logic            filter_tracking,
	output logic      [3:0] feedback_divide
);
	clk_switch_if sw ();

	// two-stage synchronisers for everything from outside clk_sys
	logic [5:0] sync1_r;
	logic [5:0] sync2_r;
	logic       xclk_d_r;
	logic       mclk_d_r;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sync1_r <= 6'h00;
			sync2_r <= 6'h00;
		end else begin
			sync1_r <= {crystal_clock, multiplied_clock, in_track_tol, out_untrack_tol,
				in_lock_tol, out_unlock_tol};
			sync2_r <= sync1_r;
		end
	end
	wire xclk_s     = sync2_r[5];
	wire mclk_s     = sync2_r[4];
	wire trk_in_s   = sync2_r[3];
	wire trk_out_s  = sync2_r[2];
	wire lock_in_s  = sync2_r[1];
	wire lock_out_s = sync2_r[0];

	// registers
	logic       irq_en_r;
	logic       flag_r;
	logic       loop_on_r;
	logic       base_sel_r;
	logic       auto_r;
	logic       lock_r;
	logic       track_auto_r;
	logic       track_man_r;
	logic [3:0] mul_r;
	logic [3:0] range_r;
	logic [7:0] rdata_r;
	logic       irq_r;
	logic       loop_en_r;
	logic       filt_r;
	logic [3:0] fdiv_r;

	wire wr_ctrl  = reg_wr && (reg_addr == ADDR_LOOP_CONTROL);
	wire wr_bw    = reg_wr && (reg_addr == ADDR_BANDWIDTH);
	wire wr_mr    = reg_wr && (reg_addr == ADDR_MULT_RANGE);
	wire rd_ctrl  = reg_rd && (reg_addr == ADDR_LOOP_CONTROL);
	wire range_ok = range_r != 4'h0;

	// interlocks judged against the values held before the write
	wire new_on   = reg_wdata[BIT_LOOP_ON];
	wire new_sel  = reg_wdata[BIT_BASE_SEL];
	wire on_chg   = new_on != loop_on_r;
	wire sel_chg  = new_sel != base_sel_r;
	wire on_ok    = on_chg && !sel_chg && (new_on || !base_sel_r);
	wire sel_ok   = sel_chg && !on_chg && (!new_sel || (loop_on_r && range_ok));
	wire loop_on_nxt  = (wr_ctrl && on_ok) ? new_on : loop_on_r;
	wire base_sel_nxt = !range_ok ? 1'b0 : ((wr_ctrl && sel_ok) ? new_sel : base_sel_r);

	// lock and track detectors with hysteresis, only alive in automatic mode
	wire lock_nxt = !auto_r ? 1'b0 :
		(lock_in_s ? 1'b1 : (lock_out_s ? 1'b0 : lock_r));
	wire track_auto_nxt = !auto_r ? 1'b0 :
		(trk_in_s ? 1'b1 : (trk_out_s ? 1'b0 : track_auto_r));
	wire lock_toggle = auto_r && (lock_nxt != lock_r);
	// set wins over the read clear so a toggle in the read cycle is kept
	wire flag_nxt = lock_toggle ? 1'b1 : (rd_ctrl ? 1'b0 : flag_r);
	wire irq_nxt  = auto_r && irq_en_r && flag_r;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_en_r   <= 1'b0;
			loop_on_r  <= LOOP_ON_RESET;
			base_sel_r <= 1'b0;
			flag_r     <= 1'b0;
		end else begin
			if (wr_ctrl && auto_r) irq_en_r <= reg_wdata[BIT_IRQ_EN];
			else if (!auto_r) irq_en_r <= 1'b0;
			loop_on_r  <= loop_on_nxt;
			base_sel_r <= base_sel_nxt;
			flag_r     <= auto_r ? flag_nxt : 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			auto_r       <= 1'b0;
			lock_r       <= 1'b0;
			track_auto_r <= 1'b0;
			track_man_r  <= 1'b0;
			mul_r        <= MUL_RESET;
			range_r      <= RANGE_RESET;
		end else begin
			if (wr_bw) auto_r <= reg_wdata[BIT_AUTO];
			// manual value kept aside while automatic mode runs
			if (wr_bw && !auto_r) track_man_r <= reg_wdata[BIT_TRACK];
			lock_r       <= lock_nxt;
			track_auto_r <= track_auto_nxt;
			if (wr_mr) begin
				mul_r   <= reg_wdata[MUL_LSB +: 4];
				range_r <= reg_wdata[RANGE_LSB +: 4];
			end
		end
	end

	// read path: data stand one cycle after the read strobe
	wire [7:0] ctrl_view = {irq_en_r & auto_r, flag_r & auto_r, loop_on_r, base_sel_r,
		CTRL_UNUSED_RD};
	wire       track_view = auto_r ? track_auto_r : track_man_r;
	wire [7:0] bw_view = {auto_r, lock_r & auto_r, track_view, 5'h00};
	wire [7:0] mr_view = {mul_r, range_r};
	wire [7:0] rd_mux = (reg_addr == ADDR_LOOP_CONTROL) ? ctrl_view :
		(reg_addr == ADDR_BANDWIDTH) ? bw_view :
		(reg_addr == ADDR_MULT_RANGE) ? mr_view : 8'h00;

	// source edge ticks for the selector; a stopped loop has no oscillator edges, so it lends
	// crystal ticks instead, otherwise a forced fall-back to the crystal would never finish
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			xclk_d_r <= 1'b0;
			mclk_d_r <= 1'b0;
		end else begin
			xclk_d_r <= xclk_s;
			mclk_d_r <= mclk_s;
		end
	end
	assign sw.xtal_tick = xclk_s & ~xclk_d_r;
	assign sw.mult_tick = loop_en_r ? (mclk_s & ~mclk_d_r) : (xclk_s & ~xclk_d_r);
	assign sw.want_mult = base_sel_r & range_ok;

	base_clock_selector u_sel (
		.clk_sys (clk_sys),
		.rst     (rst),
		.sw      (sw)
	);

	// outputs registered
	logic base_r;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata_r   <= 8'h00;
			irq_r     <= 1'b0;
			loop_en_r <= 1'b0;
			filt_r    <= 1'b0;
			fdiv_r    <= 4'h1;
			base_r    <= 1'b0;
		end else begin
			rdata_r   <= reg_rd ? rd_mux : 8'h00;
			irq_r     <= irq_nxt;
			loop_en_r <= loop_on_r & range_ok;
			filt_r    <= track_view;
			fdiv_r    <= eff_mul(mul_r);
			base_r    <= sw.base_clk;
		end
	end
	assign reg_rdata       = rdata_r;
	assign clockgen_irq    = irq_r;
	assign loop_enable     = loop_en_r;
	assign filter_tracking = filt_r;
	assign feedback_divide = fdiv_r;
	assign base_clock_out  = base_r;
endmodule

// >>> verif/clock_generator_ctrl_assertions.sv
// checker: port-level timing of the clock generator control
// assumes bind to clock_generator_ctrl, one clk_sys domain
`timescale 1ns/1ps
module clock_generator_ctrl_assertions
	import clkgen_pkg::*;
(
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       base_clock_out,
	input wire logic       clockgen_irq,
	input wire logic       loop_enable,
	input wire logic       filter_tracking,
	input wire logic [3:0] feedback_divide
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire wr_bw = reg_wr && reg_addr == ADDR_BANDWIDTH;
	wire wr_mr = reg_wr && reg_addr == ADDR_MULT_RANGE;
	// mode as last written; leaving automatic mode keeps the stored manual track value
	logic auto_seen_r;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) auto_seen_r <= 1'b0;
		else if (wr_bw) auto_seen_r <= reg_wdata[BIT_AUTO];
	end
	property p_div; feedback_divide != 4'h0; endproperty
	a_div: assert property (p_div)
		else $error("divider zero");
	property p_mul; logic [3:0] m;
		(wr_mr, m = reg_wdata[7:4]) |-> ##2 feedback_divide == ((m == 4'h0) ? 4'h1 : m);
	endproperty
	a_mul: assert property (p_mul)
		else $error("divider mismatch");
	property p_range0; wr_mr && reg_wdata[3:0] == 4'h0 |-> ##2 !loop_enable; endproperty
	a_range0: assert property (p_range0)
		else $error("loop on with range zero");
	property p_track; logic t;
		(wr_bw && !reg_wdata[BIT_AUTO] && !auto_seen_r, t = reg_wdata[BIT_TRACK]) |->
			##2 filter_tracking == t;
	endproperty
	a_track: assert property (p_track)
		else $error("filter mode mismatch");
	property p_manual_irq; wr_bw && !reg_wdata[BIT_AUTO] |-> ##2 !clockgen_irq [*3]; endproperty
	a_manual_irq: assert property (p_manual_irq)
		else $error("irq in manual mode");
	property p_irq_rd; clockgen_irq && reg_rd && reg_addr == ADDR_LOOP_CONTROL |-> ##2 !clockgen_irq;
	endproperty
	a_irq_rd: assert property (p_irq_rd)
		else $error("irq kept after read");
	property p_half; $changed(base_clock_out) |=> $stable(base_clock_out); endproperty
	a_half: assert property (p_half)
		else $error("base clock too fast");
	property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data without read");
	c_irq: cover property ($rose(clockgen_irq));
	c_base: cover property ($changed(base_clock_out));
	c_range0: cover property (wr_mr && reg_wdata[3:0] == 4'h0);
endmodule

// >>> verif/clock_generator_ctrl_tb.sv
// testbench: registers, interlocks, lock flag and base clock select
// assumes clock_generator_ctrl; sources and tolerance levels driven here
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
	$display("wrong value %s exp %0h got %0h", nm, e, g); end end
module clock_generator_ctrl_tb
	import clkgen_pkg::*;
;
	logic       clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0;
	logic       crystal_clock = 0, multiplied_clock = 0;
	logic       in_track_tol = 0, out_untrack_tol = 0, in_lock_tol = 0, out_unlock_tol = 0;
	logic [3:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0;
	logic [7:0] reg_rdata;
	logic       base_clock_out, clockgen_irq, loop_enable, filter_tracking;
	logic [3:0] feedback_divide;
	int         n_errors = 0, checks = 0, cyc = 0;
	// bench stand-ins for the acquisition and settle waits, far shorter than real ones
	localparam int acq_wait_time             = 16;
	localparam int track_to_settle_wait_time = 16;
	clock_generator_ctrl dut_u (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.crystal_clock(crystal_clock), .multiplied_clock(multiplied_clock),
		.in_track_tol(in_track_tol), .out_untrack_tol(out_untrack_tol),
		.in_lock_tol(in_lock_tol), .out_unlock_tol(out_unlock_tol),
		.base_clock_out(base_clock_out), .clockgen_irq(clockgen_irq),
		.loop_enable(loop_enable), .filter_tracking(filter_tracking),
		.feedback_divide(feedback_divide));
	always #12.5 clk_sys = ~clk_sys;
	// sources kept well below clk_sys/2 so every edge is seen
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc % 4 == 3) crystal_clock <= ~crystal_clock;
		// the oscillator only runs while the loop is enabled
		if (cyc % 3 == 2 && loop_enable) multiplied_clock <= ~multiplied_clock;
		if (cyc == 20000) begin
			n_errors++;
			end_sim();
		end
	end
	task end_sim(); begin
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	end endtask
	task wr(input logic [3:0] a, input logic [7:0] d); begin
		@(posedge clk_sys); reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
		@(posedge clk_sys); reg_wr <= 0;
	end endtask
	task rd(input logic [3:0] a, input logic [7:0] e); begin
		@(posedge clk_sys); reg_rd <= 1; reg_addr <= a;
		@(posedge clk_sys); reg_rd <= 0;
		#1 `CHK("rdata", e, reg_rdata)
	end endtask
	// cycles between two base clock changes, once the switch has settled
	task meas(input int e); int n; logic p; begin
		repeat (40) @(posedge clk_sys);
		for (int k = 0; k < 2; k++) begin
			#1 p = base_clock_out; n = 0;
			while (base_clock_out === p && n < 50) begin @(posedge clk_sys); #1 n++; end
		end
		`CHK("period", e, n)
	end endtask
	// base clock must stay frozen while the selector waits out both sources
	task hold(); logic p; begin
		repeat (2) @(posedge clk_sys);
		#1 p = base_clock_out;
		repeat (16) begin @(posedge clk_sys); #1 `CHK("hold", p, base_clock_out) end
	end endtask
	task t_reset(); begin
		rd(ADDR_LOOP_CONTROL, 8'h2F);
		rd(ADDR_BANDWIDTH, 8'h00);
		rd(ADDR_MULT_RANGE, 8'h67);
		rd(4'hF, 8'h00);
		`CHK("divide", 4'h6, feedback_divide)
	end endtask
	task t_manual(); begin
		wr(ADDR_BANDWIDTH, 8'h20); rd(ADDR_BANDWIDTH, 8'h20);
		`CHK("filter", 1'b1, filter_tracking)
		wr(ADDR_LOOP_CONTROL, 8'hA0); rd(ADDR_LOOP_CONTROL, 8'h2F);
		wr(ADDR_BANDWIDTH, 8'h00); rd(ADDR_BANDWIDTH, 8'h00);
	end endtask
	task t_prog(); begin
		wr(ADDR_MULT_RANGE, 8'h07); rd(ADDR_MULT_RANGE, 8'h07);
		`CHK("divide", 4'h1, feedback_divide)
		wr(ADDR_MULT_RANGE, 8'hF0); rd(ADDR_MULT_RANGE, 8'hF0);
		`CHK("loop", 1'b0, loop_enable)
		wr(ADDR_LOOP_CONTROL, 8'h30); rd(ADDR_LOOP_CONTROL, 8'h2F);
		wr(ADDR_MULT_RANGE, 8'h67); rd(ADDR_MULT_RANGE, 8'h67);
		`CHK("divide", 4'h6, feedback_divide)
	end endtask
	task t_select(); begin
		wr(ADDR_LOOP_CONTROL, 8'h30);
		hold();
		rd(ADDR_LOOP_CONTROL, 8'h3F);
		meas(6);
		wr(ADDR_LOOP_CONTROL, 8'h00); rd(ADDR_LOOP_CONTROL, 8'h3F);
		wr(ADDR_LOOP_CONTROL, 8'h10); rd(ADDR_LOOP_CONTROL, 8'h3F);
		wr(ADDR_LOOP_CONTROL, 8'h20);
		hold();
		rd(ADDR_LOOP_CONTROL, 8'h2F);
		meas(8);
		wr(ADDR_LOOP_CONTROL, 8'h00); rd(ADDR_LOOP_CONTROL, 8'h0F);
		wr(ADDR_LOOP_CONTROL, 8'h10); rd(ADDR_LOOP_CONTROL, 8'h0F);
		// manual start-up: acquisition first, tracking after a wait, then the select
		wr(ADDR_LOOP_CONTROL, 8'h20);
		repeat (acq_wait_time) @(posedge clk_sys);
		wr(ADDR_BANDWIDTH, 8'h20);
		repeat (track_to_settle_wait_time) @(posedge clk_sys);
		wr(ADDR_LOOP_CONTROL, 8'h30);
		rd(ADDR_LOOP_CONTROL, 8'h3F);
		`CHK("filter", 1'b1, filter_tracking)
		meas(6);
		// range zero pulls the base clock back to the crystal and stops the loop
		wr(ADDR_MULT_RANGE, 8'h60);
		rd(ADDR_LOOP_CONTROL, 8'h2F);
		meas(8);
		wr(ADDR_MULT_RANGE, 8'h67);
		wr(ADDR_BANDWIDTH, 8'h00);
	end endtask
	task t_lock(); begin
		wr(ADDR_BANDWIDTH, 8'h80); wr(ADDR_LOOP_CONTROL, 8'hA0);
		in_lock_tol <= 1;
		repeat (10) @(posedge clk_sys);
		#1 `CHK("irq", 1'b1, clockgen_irq)
		rd(ADDR_BANDWIDTH, 8'hC0);
		rd(ADDR_LOOP_CONTROL, 8'hEF);
		rd(ADDR_LOOP_CONTROL, 8'hAF);
		`CHK("irq", 1'b0, clockgen_irq)
		@(posedge clk_sys);
		in_track_tol <= 1;
		repeat (8) @(posedge clk_sys);
		rd(ADDR_BANDWIDTH, 8'hE0);
		`CHK("filter", 1'b1, filter_tracking)
		@(posedge clk_sys);
		in_lock_tol <= 0;
		out_unlock_tol <= 1;
		repeat (10) @(posedge clk_sys);
		rd(ADDR_BANDWIDTH, 8'hA0);
		wr(ADDR_BANDWIDTH, 8'h00); rd(ADDR_LOOP_CONTROL, 8'h2F);
		`CHK("irq", 1'b0, clockgen_irq)
	end endtask
	initial begin
		repeat (5) @(posedge clk_sys);
		rst <= 0;
		t_reset(); t_manual(); t_prog(); t_select(); t_lock();
		end_sim();
	end
endmodule
bind clock_generator_ctrl clock_generator_ctrl_assertions chk_u (.clk_sys(clk_sys), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .base_clock_out(base_clock_out), .clockgen_irq(clockgen_irq),
	.loop_enable(loop_enable), .filter_tracking(filter_tracking),
	.feedback_divide(feedback_divide));
